// ==== design/dual_rail_startup_sequencer.sv ====
// Start-up sequencer for two switching rails with a Wishbone register slave.
`timescale 1ns/1ps
module dual_rail_startup_sequencer #(
  parameter int SWITCH_PERIOD = startup_seq_pkg::SWITCH_PERIOD_CYCLES,
  parameter int STARTUP_HOLD = startup_seq_pkg::STARTUP_HOLD_SWITCH_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [startup_seq_pkg::ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ,
  input wire logic [1:0] ORDER_SELECT,
  input wire logic LOW_RAIL_ENABLE,
  input wire logic HIGH_RAIL_ENABLE,
  input wire logic LOW_RAIL_UNDERVOLT,
  input wire logic HIGH_RAIL_UNDERVOLT,
  input wire logic LOW_RAIL_OVERCURRENT,
  input wire logic HIGH_RAIL_OVERCURRENT,
  input wire logic LOW_RAIL_PWM,
  input wire logic HIGH_RAIL_PWM,
  output logic LOW_RAIL_RUN,
  output logic HIGH_RAIL_RUN,
  output logic LOW_RAIL_GATE,
  output logic HIGH_RAIL_GATE,
  output logic SYSTEM_OK_OUT,
  output logic SYSTEM_OK_OE
);
  import startup_seq_pkg::*;

  localparam int SW_W = $clog2(SWITCH_PERIOD + 1);
  localparam int HOLD_W = $clog2(STARTUP_HOLD + 1);
  localparam logic [SW_W-1:0] SW_LAST = SW_W'(SWITCH_PERIOD - 1);
  localparam logic [HOLD_W-1:0] HOLD_END = HOLD_W'(STARTUP_HOLD);

  typedef struct packed {
    logic [SW_W-1:0] sw_cnt;
    mode_t mode;
    logic low_en;
    logic high_en;
    seq_t seq;
    logic [1:0] run;
    logic [1:0] limited;
    logic [1:0] gate;
    logic [1:0] uv_seen;
    logic [HOLD_W-1:0] hold;
    logic sys_ok;
    logic standby;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t r;
  state_t next_r;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic mode_t decode_mode(input logic [1:0] sel);
    unique case (sel)
      ORDER_SEL_GROUND: decode_mode = MODE_HIGH_FIRST;
      ORDER_SEL_BIAS_RAIL: decode_mode = MODE_LOW_FIRST;
      default: decode_mode = MODE_INDEPENDENT;
    endcase
  endfunction

  logic tick;
  logic startup_done;
  logic [1:0] undervolt;
  logic [1:0] overcurrent;
  logic [1:0] pwm;
  logic wb_req;
  logic wb_take;
  logic ok_cond;
  logic first_ok;
  logic second_ok;
  logic [INT_W-1:0] events;

  assign tick = (r.sw_cnt == '0);
  assign startup_done = (r.hold == HOLD_END);
  assign undervolt = {HIGH_RAIL_UNDERVOLT, LOW_RAIL_UNDERVOLT};
  assign overcurrent = {HIGH_RAIL_OVERCURRENT, LOW_RAIL_OVERCURRENT};
  assign pwm = {HIGH_RAIL_PWM, LOW_RAIL_PWM};
  assign wb_req = WB_CYC_I & WB_STB_I;
  assign wb_take = wb_req & r.ack;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.sw_cnt = tick ? SW_LAST : r.sw_cnt - 1'b1;
    if (tick) begin
      next_r.mode = decode_mode(ORDER_SELECT);
      next_r.low_en = LOW_RAIL_ENABLE;
      next_r.high_en = HIGH_RAIL_ENABLE;
    end

    // The first rail must regulate before the second one starts.
    first_ok = (r.mode == MODE_HIGH_FIRST) ? !undervolt[1] : !undervolt[0];
    second_ok = (r.mode == MODE_HIGH_FIRST) ? !undervolt[0] : !undervolt[1];
    if (r.mode == MODE_INDEPENDENT || !r.low_en || r.standby) begin
      next_r.seq = SEQ_IDLE;
    end else begin
      unique case (r.seq)
        SEQ_IDLE: next_r.seq = SEQ_FIRST;
        SEQ_FIRST: next_r.seq = (r.high_en && first_ok) ? SEQ_BOTH : SEQ_FIRST;
        SEQ_BOTH: next_r.seq = r.high_en ? SEQ_BOTH : SEQ_FIRST;
      endcase
    end

    unique case (r.mode)
      MODE_INDEPENDENT: next_r.run = {r.high_en, r.low_en};
      MODE_HIGH_FIRST:
        next_r.run = {next_r.seq != SEQ_IDLE, next_r.seq == SEQ_BOTH};
      MODE_LOW_FIRST:
        next_r.run = {next_r.seq == SEQ_BOTH, next_r.seq != SEQ_IDLE};
      default: next_r.run = 2'h0;
    endcase
    if (r.standby) begin
      next_r.run = 2'h0;
    end

    // A limit hit blocks the gate until the next switching cycle begins.
    for (int i = 0; i < 2; i++) begin
      next_r.limited[i] = overcurrent[i] | (r.limited[i] & !tick);
      next_r.gate[i] = pwm[i] & next_r.run[i] & !next_r.limited[i];
    end

    if (next_r.run == 2'h0) begin
      next_r.hold = '0;
    end else if (tick && !startup_done) begin
      next_r.hold = r.hold + 1'b1;
    end

    if (r.mode == MODE_INDEPENDENT) begin
      ok_cond = !(!r.low_en && r.high_en) && !undervolt[0];
    end else begin
      ok_cond = r.low_en && r.seq != SEQ_IDLE && first_ok &&
                (!r.high_en || (r.seq == SEQ_BOTH && second_ok));
    end
    next_r.sys_ok = ok_cond && startup_done;

    next_r.uv_seen = undervolt & r.run;
    events = '0;
    events[INT_SYS_OK_RISE] = next_r.sys_ok & !r.sys_ok;
    events[INT_SYS_OK_FALL] = !next_r.sys_ok & r.sys_ok;
    events[INT_OVERCURRENT_LSB +: 2] = overcurrent & r.run;
    events[INT_UNDERVOLT_LSB +: 2] = next_r.uv_seen & ~r.uv_seen;

    // Only bits that were handed out in the read data are cleared.
    next_r.int_stat = r.int_stat | events;
    if (wb_take && !WB_WE_I && WB_ADR_I == INT_STATUS_OFFSET) begin
      next_r.int_stat = (r.int_stat & ~r.rdata[INT_W-1:0]) | events;
    end

    if (wb_take && WB_WE_I && WB_SEL_I[0]) begin
      if (WB_ADR_I == CONTROL_OFFSET) begin
        next_r.standby = WB_DAT_I[CONTROL_STANDBY_BIT];
      end
      if (WB_ADR_I == INT_MASK_OFFSET) begin
        next_r.int_mask = WB_DAT_I[INT_W-1:0];
      end
    end
    next_r.irq = |(next_r.int_stat & next_r.int_mask);

    next_r.ack = wb_req & !r.ack;
    next_r.rdata = '0;
    if (wb_req && !r.ack && !WB_WE_I) begin
      unique case (WB_ADR_I)
        STATUS_OFFSET: begin
          next_r.rdata[STATUS_RUN_LOW_BIT] = r.run[0];
          next_r.rdata[STATUS_RUN_HIGH_BIT] = r.run[1];
          next_r.rdata[STATUS_SYS_OK_BIT] = r.sys_ok;
          next_r.rdata[STATUS_DONE_BIT] = startup_done;
          next_r.rdata[STATUS_MODE_LSB +: 2] = r.mode;
          next_r.rdata[STATUS_SEQ_LSB +: 2] = r.seq;
        end
        CONTROL_OFFSET: next_r.rdata[CONTROL_STANDBY_BIT] = r.standby;
        INT_STATUS_OFFSET: next_r.rdata[INT_W-1:0] = r.int_stat;
        INT_MASK_OFFSET: next_r.rdata[INT_W-1:0] = r.int_mask;
        default: next_r.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      r <= '0;
      r.mode <= MODE_INDEPENDENT;
      r.seq <= SEQ_IDLE;
      r.standby <= CONTROL_STANDBY_RESET;
      r.int_mask <= INT_MASK_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign WB_DAT_O = r.rdata;
  assign WB_ACK_O = r.ack;
  assign IRQ = r.irq;
  assign LOW_RAIL_RUN = r.run[0];
  assign HIGH_RAIL_RUN = r.run[1];
  assign LOW_RAIL_GATE = r.gate[0];
  assign HIGH_RAIL_GATE = r.gate[1];
  assign SYSTEM_OK_OUT = 1'b0;
  assign SYSTEM_OK_OE = !r.sys_ok;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  chk_indep_both_off: assert property (
    r.mode == MODE_INDEPENDENT && !r.low_en && !r.high_en
    |=> !LOW_RAIL_RUN && !HIGH_RAIL_RUN
  ) else $error("Independent mode with both enables low left a rail running.");

  chk_indep_high_only: assert property (
    r.mode == MODE_INDEPENDENT && !r.low_en && r.high_en && !r.standby
    |=> HIGH_RAIL_RUN && !LOW_RAIL_RUN && SYSTEM_OK_OE
  ) else $error("High rail alone did not run with system ok held low.");

  chk_indep_follow_low: assert property (
    r.mode == MODE_INDEPENDENT && r.low_en
    |=> r.sys_ok == $past(startup_done && !LOW_RAIL_UNDERVOLT)
  ) else $error("System ok did not follow the low rail alone.");

  chk_high_first: assert property (
    r.mode == MODE_HIGH_FIRST && r.low_en && !r.high_en && !r.standby
    |=> HIGH_RAIL_RUN && !LOW_RAIL_RUN
  ) else $error("Ground order did not run the high rail alone.");

  chk_low_first: assert property (
    r.mode == MODE_LOW_FIRST && r.low_en && !r.high_en && !r.standby
    |=> LOW_RAIL_RUN && !HIGH_RAIL_RUN
  ) else $error("Bias order did not run the low rail alone.");

  chk_seq_disabled: assert property (
    r.mode != MODE_INDEPENDENT && !r.low_en
    |=> !LOW_RAIL_RUN && !HIGH_RAIL_RUN && SYSTEM_OK_OE
  ) else $error("Sequenced mode with low enable low kept a rail or system ok.");

  chk_current_limit: assert property (
    LOW_RAIL_OVERCURRENT |=> !LOW_RAIL_GATE
  ) else $error("Low rail gate stayed on after an overcurrent.");

  chk_limit_holds: assert property (
    HIGH_RAIL_OVERCURRENT ##1 !tick |=> !HIGH_RAIL_GATE
  ) else $error("High rail gate returned before the next switching cycle.");

  chk_startup_hold: assert property (
    !startup_done |=> SYSTEM_OK_OE
  ) else $error("System ok released before the start-up hold ended.");

  chk_undervolt_low: assert property (
    LOW_RAIL_UNDERVOLT && LOW_RAIL_RUN && (r.mode != MODE_HIGH_FIRST || r.high_en)
    |=> SYSTEM_OK_OE
  ) else $error("Low rail undervoltage did not pull system ok low.");

  chk_sample_tick: assert property (
    !tick |=> $stable(r.low_en) && $stable(r.high_en) && $stable(r.mode)
  ) else $error("Enables changed between switching cycle samples.");

endmodule

// ==== design/startup_seq_pkg.sv ====
// Constants, types and the behaviour summary of the dual rail start-up sequencer.
// How it works
// - With order select at the reference level each enable runs its own rail, low enable the 3.3V rail and high enable the 5V rail, and both rails are off while both enables are low.
// - In independent mode with the low enable low and the high enable high only the 5V rail runs and system ok is held low.
// - In independent mode with the low enable high, system ok follows only the 3.3V rail regulation and ignores the 5V rail.
// - With order select at ground a high low enable starts the 5V rail first and the high enable decides whether the 3.3V rail follows.
// - With order select at the bias rail a high low enable starts the 3.3V rail first and the high enable decides whether the 5V rail follows.
// - In either sequenced mode both rails are off and system ok is low while the low enable is low, and system ok is released only once the rails are in regulation.
// - Each switching action ends at once when the sensed current exceeds the limit threshold, cycle by cycle.
// - After start-up system ok is held low for a fixed count of switching cycles whatever the outputs do.
// - System ok is pulled low whenever a monitored output sits more than the undervoltage margin below nominal.
package startup_seq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 5'h00;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 5'h04;
  localparam logic [ADDR_W-1:0] INT_STATUS_OFFSET = 5'h08;
  localparam logic [ADDR_W-1:0] INT_MASK_OFFSET = 5'h0C;

  localparam int STATUS_RUN_LOW_BIT = 0;
  localparam int STATUS_RUN_HIGH_BIT = 1;
  localparam int STATUS_SYS_OK_BIT = 2;
  localparam int STATUS_DONE_BIT = 3;
  localparam int STATUS_MODE_LSB = 4;
  localparam int STATUS_SEQ_LSB = 6;
  localparam int CONTROL_STANDBY_BIT = 0;

  localparam int INT_W = 6;
  localparam int INT_SYS_OK_RISE = 0;
  localparam int INT_SYS_OK_FALL = 1;
  localparam int INT_OVERCURRENT_LSB = 2;
  localparam int INT_UNDERVOLT_LSB = 4;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 6'h00;
  localparam logic CONTROL_STANDBY_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Pin encodings and modes
  // ----------------------------------------------------------------
  localparam logic [1:0] ORDER_SEL_GROUND = 2'h0;
  localparam logic [1:0] ORDER_SEL_REFERENCE = 2'h1;
  localparam logic [1:0] ORDER_SEL_BIAS_RAIL = 2'h2;

  typedef enum logic [1:0] {
    MODE_INDEPENDENT,
    MODE_HIGH_FIRST,
    MODE_LOW_FIRST
  } mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FIRST,
    SEQ_BOTH
  } seq_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int SWITCH_FREQ_KHZ = 300;
  localparam int SWITCH_PERIOD_CYCLES = CLK_FREQ_KHZ / SWITCH_FREQ_KHZ;
  localparam int STARTUP_HOLD_SWITCH_CYCLES = 32768;

endpackage

// ==== verification/host_ctrl_model.sv ====
// Host controller model: drives order select and enables, resolves the system ok line.
`timescale 1ns/1ps
module host_ctrl_model (
  input wire logic clk,
  input wire logic [3:0] cmd,
  input wire logic ok_out,
  input wire logic ok_oe,
  output logic [1:0] order_sel = 2'h1,
  output logic low_en = 1'h0,
  output logic high_en = 1'h0,
  output logic sys_ok
);
  // The line has a pull-up, so it reads high unless the device pulls it.
  assign sys_ok = ok_oe ? ok_out : 1'h1;
  always @(posedge clk) begin
    order_sel <= cmd[3:2];
    low_en <= cmd[1];
    high_en <= cmd[0];
  end
endmodule

// ==== verification/tb_dual_rail_startup_sequencer.sv ====
// Self-checking bench of the dual rail start-up sequencer.
`timescale 1ns/1ps
module tb_dual_rail_startup_sequencer;
  import startup_seq_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, probe = 1'h0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack, irq, run_l, run_h, gate_l, gate_h, ok_out, ok_oe, en_l, en_h, sys_ok;
  logic uv_l = 1'h0, uv_h = 1'h0, oc_l = 1'h0, oc_h = 1'h0, pwm_l = 1'h0, pwm_h = 1'h0;
  logic [1:0] ord;
  logic [3:0] cmd = 4'h4;
  logic [63:0] bus_q[$];
  logic [11:0] pin_q[$];
  int errors = 0;
  int checks = 0;

  always #2 core_clk = ~core_clk;

  dual_rail_startup_sequencer #(.SWITCH_PERIOD(4), .STARTUP_HOLD(4)) i_dut (
    .CORE_CLK(core_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .IRQ(irq), .ORDER_SELECT(ord), .LOW_RAIL_ENABLE(en_l), .HIGH_RAIL_ENABLE(en_h),
    .LOW_RAIL_UNDERVOLT(uv_l), .HIGH_RAIL_UNDERVOLT(uv_h), .LOW_RAIL_OVERCURRENT(oc_l),
    .HIGH_RAIL_OVERCURRENT(oc_h), .LOW_RAIL_PWM(pwm_l), .HIGH_RAIL_PWM(pwm_h),
    .LOW_RAIL_RUN(run_l), .HIGH_RAIL_RUN(run_h), .LOW_RAIL_GATE(gate_l),
    .HIGH_RAIL_GATE(gate_h), .SYSTEM_OK_OUT(ok_out), .SYSTEM_OK_OE(ok_oe));

  host_ctrl_model i_host (.clk(core_clk), .cmd(cmd), .ok_out(ok_out), .ok_oe(ok_oe),
    .order_sel(ord), .low_en(en_l), .high_en(en_h), .sys_ok(sys_ok));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wb_cycle(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge core_clk);
    while (ack !== 1'h1) @(posedge core_clk);
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic wb_read(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v);
    bus_q.push_back({m, v});
    wb_cycle(1'h0, a, 32'h0);
  endtask

  task automatic probe_pins(input logic [5:0] m, input logic [5:0] v);
    pin_q.push_back({m, v});
    probe <= 1'h1;
    @(posedge core_clk);
    probe <= 1'h0;
  endtask

  function automatic logic [2:0] exp_pins(input logic [1:0] m, input logic le, input logic he);
    if (m != ORDER_SEL_GROUND && m != ORDER_SEL_BIAS_RAIL) begin
      return {le, he, le};
    end
    return {le & (m == ORDER_SEL_BIAS_RAIL | he), le & (m == ORDER_SEL_GROUND | he), le};
  endfunction

  // ----------------------------------------------------------------
  // Monitor: takes the oldest note whenever a result appears
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    logic [63:0] b;
    logic [11:0] p;
    if (ack === 1'h1 && we === 1'h0 && bus_q.size() > 0) begin
      b = bus_q.pop_front();
      check(dat_o & b[63:32], b[31:0]);
    end
    if (probe === 1'h1) begin
      p = pin_q.pop_front();
      check({26'h0, {run_l, run_h, sys_ok, irq, gate_l, gate_h} & p[11:6]}, {26'h0, p[5:0]});
    end
  end

  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] modes[4];
    logic [1:0] r;
    modes = '{ORDER_SEL_REFERENCE, ORDER_SEL_GROUND, ORDER_SEL_BIAS_RAIL, 2'h3};
    void'($urandom(64341));
    wait_cyc(4);
    rst <= 1'h0;
    cmd <= {ORDER_SEL_REFERENCE, 2'h2};
    wait_cyc(12);
    probe_pins(6'h38, 6'h20);
    wait_cyc(30);
    probe_pins(6'h38, 6'h28);
    $display("test startup hold done");
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 4; e++) begin
        cmd <= {modes[m], e[1:0]};
        wait_cyc(40);
        probe_pins(6'h38, {exp_pins(modes[m], e[1], e[0]), 3'h0});
      end
    end
    $display("test order table done");
    cmd <= {ORDER_SEL_REFERENCE, 2'h3};
    wait_cyc(40);
    wb_read(INT_STATUS_OFFSET, 32'hFFFFFFFF, 32'h03);
    wb_cycle(1'h1, INT_MASK_OFFSET, 32'h02);
    uv_h <= 1'($urandom);
    wait_cyc(4);
    probe_pins(6'h3C, 6'h38);
    uv_l <= 1'h1;
    wait_cyc(4);
    probe_pins(6'h3C, 6'h34);
    wb_read(INT_STATUS_OFFSET, 32'h3F, {26'h0, uv_h, 5'h12});
    wait_cyc(2);
    probe_pins(6'h04, 6'h00);
    uv_l <= 1'h0;
    uv_h <= 1'h0;
    $display("test undervolt and interrupt done");
    wait_cyc(4);
    r = 2'($urandom);
    pwm_l <= r[1];
    pwm_h <= r[0];
    wait_cyc(3);
    probe_pins(6'h03, {4'h0, r});
    pwm_l <= 1'h1;
    pwm_h <= 1'h1;
    oc_l <= 1'h1;
    wait_cyc(3);
    probe_pins(6'h03, 6'h01);
    oc_l <= 1'h0;
    oc_h <= 1'h1;
    wait_cyc(1);
    oc_h <= 1'h0;
    probe_pins(6'h01, 6'h00);
    $display("test current limit done");
    wb_read(CONTROL_OFFSET, 32'hFFFFFFFF, 32'h0);
    wb_cycle(1'h1, CONTROL_OFFSET, 32'h1);
    wb_read(CONTROL_OFFSET, 32'hFFFFFFFF, 32'h1);
    wait_cyc(12);
    probe_pins(6'h38, 6'h00);
    wb_read(STATUS_OFFSET, 32'h0F, 32'h0);
    wb_read(5'h10, 32'hFFFFFFFF, 32'h0);
    wb_cycle(1'h1, CONTROL_OFFSET, 32'h0);
    $display("test registers done");
    tally_and_finish();
  end
endmodule
